/* File: inc/fifo_ofs_map.svh */
`ifndef FIFO_OFS_MAP_SVH
`define FIFO_OFS_MAP_SVH

// Register byte offsets on the Wishbone slave
`define ADDR_CFG 4'h0
`define ADDR_STAT 4'h4
`define ADDR_EMPTY_OFS 4'h8
`define ADDR_FULL_OFS 4'hC

// Configuration register fields and reset value
`define CFG_IN18_BIT 0
`define CFG_OUT18_BIT 1
`define CFG_VARIANT_LO 2
`define CFG_RESET 4'h0

// Offset register width and the value loaded by master reset
`define OFS_W 17
`define EMPTY_OFS_RESET 17'h0007F
`define FULL_OFS_RESET 17'h0007F

// Serial offset width of the smallest variant outside byte-to-byte mode
`define SER_BASE_BITS 5'h0D

// Bits per offset part on a byte bus
`define BYTE_PART_BITS 8

// Flag settling: rising edges of the counting clock after completion
`define SETTLE_EDGES 2'h2

`endif

/* File: inc/fifo_ofs_pkg.sv */
package fifo_ofs_pkg;
  `include "fifo_ofs_map.svh"

  typedef logic [`OFS_W-1:0] offset_t;
  typedef logic [2:0] ptr_t;
  typedef logic [17:0] word_t;
  typedef enum logic [1:0] {ST_VALID, ST_WAIT, ST_INVALID} settle_t;

  // Writes or reads per offset register for a given bus width
  function automatic logic [1:0] parts_per_reg(input logic bus18, input logic deep9);
    parts_per_reg = bus18 ? 2'h1 : (deep9 ? 2'h3 : 2'h2);
  endfunction : parts_per_reg

  // Offset pointer step; wraps after the last full-offset part
  function automatic ptr_t ptr_next(input ptr_t ptr, input logic [1:0] parts);
    ptr_t last;
    last = ptr_t'({parts, 1'b0}) - 3'h1;
    ptr_next = (ptr == last) ? 3'h0 : ptr + 3'h1;
  endfunction : ptr_next

  // Offset width in bits for the current bus combination and depth variant
  function automatic logic [4:0] ofs_bits(input logic x9x9, input logic [1:0] variant);
    ofs_bits = `SER_BASE_BITS + {3'h0, variant} + {4'h0, x9x9};
  endfunction : ofs_bits

  // Merge one bus word into an offset register
  function automatic offset_t ofs_merge(input offset_t old, input word_t d, input logic [1:0] part,
                                        input logic bus18);
    logic [23:0] t;
    t = {7'h00, old};
    t[part*`BYTE_PART_BITS +: `BYTE_PART_BITS] = d[7:0];
    ofs_merge = bus18 ? d[`OFS_W-1:0] : t[`OFS_W-1:0];
  endfunction : ofs_merge

  // Slice of an offset register presented on the data outputs
  function automatic word_t ofs_slice(input offset_t val, input logic [1:0] part, input logic bus18);
    logic [23:0] t;
    t = {7'h00, val};
    ofs_slice = bus18 ? {1'b0, val} : {10'h000, t[part*`BYTE_PART_BITS +: `BYTE_PART_BITS]};
  endfunction : ofs_slice
endpackage : fifo_ofs_pkg

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ns
// Two-stage synchroniser for pins, plus a third stage used only for edge detection
module pin_sync #(
  parameter int W = 27
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // The first stage feeds only the second, so metastability never reaches logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else if (ce_i) begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Level and rising edge from the settled stages
  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;
endmodule : pin_sync

/* File: verilog/flag_settle.sv */
`timescale 1ns/1ns
`include "fifo_ofs_map.svh"
// Tracks whether one programmable flag may be trusted
module flag_settle (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic home_i,
  input wire logic clear_i,
  input wire logic done_i,
  input wire logic edge_i,
  output logic valid_o
);
  import fifo_ofs_pkg::*;

  settle_t state_reg;
  logic [1:0] cnt_reg;
  logic valid_reg;

  // Completion wins over invalidation; edges count only after the completing one
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && home_i)) begin
      state_reg <= ST_VALID;
      cnt_reg <= 2'h0;
      valid_reg <= 1'b1;
    end else if (ce_i) begin
      case (state_reg)
        ST_VALID, ST_INVALID: begin
          if (done_i) begin
            state_reg <= ST_WAIT;
            cnt_reg <= 2'h0;
            valid_reg <= 1'b0;
          end else if (clear_i) begin
            state_reg <= ST_INVALID;
            valid_reg <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (done_i) begin
            cnt_reg <= 2'h0;
          end else if (clear_i) begin
            state_reg <= ST_INVALID;
          end else if (edge_i) begin
            if (cnt_reg == `SETTLE_EDGES - 2'h1) begin
              state_reg <= ST_VALID;
              valid_reg <= 1'b1;
            end
            cnt_reg <= cnt_reg + 2'h1;
          end
        end
        default: begin
          state_reg <= ST_INVALID;
          valid_reg <= 1'b0;
        end
      endcase
    end
  end

  assign valid_o = valid_reg;
endmodule : flag_settle

/* File: verilog/flag_offset_programmer.sv */
`timescale 1ns/1ns
// How it works
// - Offset-load and serial-enable low: one serial bit per write-clock edge, empty LSB first.
// - Byte-to-byte buses: serial load is 28, 30, 32 or 34 bits by depth.
// - Other bus combinations: serial load is two bits shorter, 26 to 32.
// - Serial mode loads no single register; flags invalid until all bits arrive.
// - Serial reprogramming may repeat any number of times with complete bit sets.
// - Offset-load low, serial-enable high: no serial shift happens.
// - Serial load pauses on either control high; memory writes allowed meanwhile; resumes in sequence.
// - Full flag valid two write edges after completion, empty flag two read edges.
// - No serial readback path for the offsets.
// - Parallel load takes two writes on 18 bits, four on bytes, six deepest byte-byte.
// - Separate independent write and read offset pointers; host avoids simultaneous access.
// - Master reset homes both pointers; partial reset leaves them alone.
// - Offset-load high redirects writes to memory; low again resumes next part.
// - In parallel loading, each flag invalid until its own offset word completes.
// - Offset-load and read-enable low: each read edge presents the next offset part.
// - Readback takes two reads on 18 bits, four on bytes, six deepest byte-byte.
// - Readback pauses on either control high and resumes where it stopped.
// - An offset read replaces whatever memory word was on the data outputs.
// - Offset readback works in both fall-through and standard timing.
// - Serial or parallel loading is latched only at master reset.
// - Offset readback is allowed whichever loading method was chosen.
`include "fifo_ofs_map.svh"
module flag_offset_programmer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic write_clock_i,
  input wire logic read_clock_i,
  input wire logic master_reset_n_i,
  input wire logic offset_load_n_i,
  input wire logic serial_shift_enable_n_i,
  input wire logic write_enable_n_i,
  input wire logic read_enable_n_i,
  input wire logic serial_in_i,
  input wire logic serial_select_i,
  input wire fifo_ofs_pkg::word_t data_inputs_i,
  input wire fifo_ofs_pkg::word_t mem_read_data_i,
  input wire logic fall_through_timing_i,
  output fifo_ofs_pkg::word_t data_outputs_o,
  output logic almost_empty_valid_o,
  output logic almost_full_valid_o,
  output logic mem_write_o,
  output logic mem_read_o,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  import fifo_ofs_pkg::*;

  // Synchronised pin levels and clock-pin edges
  logic [26:0] pin_level;
  logic [26:0] pin_rise;
  logic w_rise;
  logic r_rise;
  logic mrst;
  logic ld_n;
  logic sen_n;
  logic wen_n;
  logic ren_n;
  logic si;
  logic ser_sel;
  word_t din;

  // State
  logic [3:0] cfg_reg;
  logic serial_mode_reg;
  offset_t empty_reg;
  offset_t full_reg;
  ptr_t wp_reg;
  ptr_t rp_reg;
  logic [5:0] ser_idx_reg;
  word_t dout_reg;
  logic mem_write_reg;
  logic mem_read_reg;
  logic ack_reg;
  logic [31:0] dat_reg;

  // Decode wires
  logic in18;
  logic out18;
  logic [1:0] variant;
  logic x9x9;
  logic deep9;
  logic [1:0] w_parts;
  logic [1:0] r_parts;
  logic [4:0] ofs_w;
  logic ser_shift;
  logic ser_first;
  logic ser_last;
  logic ser_in_full;
  logic [4:0] ser_bit;
  logic par_write;
  logic wp_in_full;
  logic [1:0] wp_part;
  logic wp_first;
  logic wp_last;
  logic ofs_read;
  logic rp_in_full;
  logic [1:0] rp_part;
  word_t rd_word;
  offset_t wr_target;
  offset_t wr_merged;
  logic mem_wr;
  logic mem_rd;
  logic e_clear;
  logic e_done;
  logic f_clear;
  logic f_done;
  logic empty_valid;
  logic full_valid;
  logic wb_take;
  logic cfg_write;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;

  // Every pin, strobes and data alike, passes the same two flip-flops
  pin_sync #(
    .W(27)
  ) u_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i({write_clock_i, read_clock_i, master_reset_n_i, offset_load_n_i, serial_shift_enable_n_i,
            write_enable_n_i, read_enable_n_i, serial_in_i, serial_select_i, data_inputs_i}),
    .level_o(pin_level),
    .rise_o(pin_rise)
  );

  assign w_rise = pin_rise[26];
  assign r_rise = pin_rise[25];
  assign mrst = ~pin_level[24];
  assign ld_n = pin_level[23];
  assign sen_n = pin_level[22];
  assign wen_n = pin_level[21];
  assign ren_n = pin_level[20];
  assign si = pin_level[19];
  assign ser_sel = pin_level[18];
  assign din = pin_level[17:0];

  // Bus configuration and derived sizes
  assign in18 = cfg_reg[`CFG_IN18_BIT];
  assign out18 = cfg_reg[`CFG_OUT18_BIT];
  assign variant = cfg_reg[`CFG_VARIANT_LO +: 2];
  assign x9x9 = ~in18 & ~out18;
  assign deep9 = x9x9 & (variant == 2'h3);
  assign w_parts = parts_per_reg(in18, deep9);
  assign r_parts = parts_per_reg(out18, deep9);
  assign ofs_w = ofs_bits(x9x9, variant);

  // Serial shift path; a high serial enable halts it, so a pause resumes in sequence
  assign ser_shift = w_rise & ~ld_n & ~sen_n & serial_mode_reg & ~mrst;
  assign ser_first = ser_shift & (ser_idx_reg == 6'h00);
  assign ser_last = ser_idx_reg == ({1'b0, ofs_w} << 1) - 6'h01;
  assign ser_in_full = ser_idx_reg >= {1'b0, ofs_w};
  assign ser_bit = ser_in_full ? 5'(ser_idx_reg - {1'b0, ofs_w}) : ser_idx_reg[4:0];

  // Parallel write path, only in parallel mode
  assign par_write = w_rise & ~ld_n & ~wen_n & ~serial_mode_reg & ~mrst;
  assign wp_in_full = wp_reg >= {1'b0, w_parts};
  assign wp_part = wp_in_full ? 2'(wp_reg - {1'b0, w_parts}) : wp_reg[1:0];
  assign wp_first = wp_part == 2'h0;
  assign wp_last = wp_part == w_parts - 2'h1;
  assign wr_target = wp_in_full ? full_reg : empty_reg;
  assign wr_merged = ofs_merge(wr_target, din, wp_part, in18);

  // Parallel readback path, open in either loading method and either timing
  assign ofs_read = r_rise & ~ld_n & ~ren_n & ~mrst;
  assign rp_in_full = rp_reg >= {1'b0, r_parts};
  assign rp_part = rp_in_full ? 2'(rp_reg - {1'b0, r_parts}) : rp_reg[1:0];
  assign rd_word = ofs_slice(rp_in_full ? full_reg : empty_reg, rp_part, out18);

  // Memory strokes only while offset-load is high
  assign mem_wr = w_rise & ld_n & ~wen_n & ~mrst;
  assign mem_rd = r_rise & ld_n & ~ren_n & ~mrst;

  // Flag validity events: serial start or empty-word start voids both flags, full-word start only the full flag; each returns only with its own word
  assign e_clear = ser_first | (par_write & ~wp_in_full & wp_first);
  assign f_clear = ser_first | (par_write & wp_first);
  assign e_done = (ser_shift & ser_last) | (par_write & ~wp_in_full & wp_last);
  assign f_done = (ser_shift & ser_last) | (par_write & wp_in_full & wp_last);

  // Almost-empty settles on read-clock edges
  flag_settle u_empty (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .home_i(mrst),
    .clear_i(e_clear),
    .done_i(e_done),
    .edge_i(r_rise),
    .valid_o(empty_valid)
  );

  // Almost-full settles on write-clock edges
  flag_settle u_full (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .home_i(mrst),
    .clear_i(f_clear),
    .done_i(f_done),
    .edge_i(w_rise),
    .valid_o(full_valid)
  );

  // Loading method is caught only while master reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_mode_reg <= 1'b0;
    end else if (ce_i && mrst) begin
      serial_mode_reg <= ser_sel;
    end
  end

  // Offset registers; serial bits land one at a time, the set only counts when whole
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && mrst)) begin
      empty_reg <= `EMPTY_OFS_RESET;
      full_reg <= `FULL_OFS_RESET;
    end else if (ce_i && ser_shift && !ser_in_full) begin
      empty_reg[ser_bit] <= si;
    end else if (ce_i && ser_shift) begin
      full_reg[ser_bit] <= si;
    end else if (ce_i && par_write && !wp_in_full) begin
      empty_reg <= wr_merged;
    end else if (ce_i && par_write) begin
      full_reg <= wr_merged;
    end
  end

  // Serial bit counter wraps so a fresh full set can follow at any time
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && mrst)) begin
      ser_idx_reg <= 6'h00;
    end else if (ce_i && ser_shift) begin
      ser_idx_reg <= ser_last ? 6'h00 : ser_idx_reg + 6'h01;
    end
  end

  // Independent pointers; partial reset has no say here
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && mrst)) begin
      wp_reg <= 3'h0;
      rp_reg <= 3'h0;
    end else if (ce_i) begin
      if (par_write) begin
        wp_reg <= ptr_next(wp_reg, w_parts);
      end
      if (ofs_read) begin
        rp_reg <= ptr_next(rp_reg, r_parts);
      end
    end
  end

  // Data outputs: an offset read overwrites the held memory word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_reg <= 18'h00000;
    end else if (ce_i && ofs_read) begin
      dout_reg <= rd_word;
    end else if (ce_i && mem_rd) begin
      dout_reg <= mem_read_data_i;
    end
  end

  // Memory pointer strokes, one clock wide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_write_reg <= 1'b0;
      mem_read_reg <= 1'b0;
    end else if (ce_i) begin
      mem_write_reg <= mem_wr;
      mem_read_reg <= mem_rd;
    end
  end

  // Wishbone decode; unmapped addresses answer with zero and ignore writes
  // A write lands at the edge that sees ack high, while the master still holds the request
  assign wb_take = cyc_i & stb_i & ~ack_reg;
  assign cfg_write = cyc_i & stb_i & ack_reg & we_i & sel_i[0] & (adr_i == `ADDR_CFG);
  assign stat_word = {13'h0000, empty_valid, full_valid, serial_mode_reg, fall_through_timing_i, 1'b0,
                      ser_idx_reg, 1'b0, rp_reg, 1'b0, wp_reg};
  assign rd_mux = (adr_i == `ADDR_CFG) ? {28'h0000000, cfg_reg} :
                  (adr_i == `ADDR_STAT) ? stat_word :
                  (adr_i == `ADDR_EMPTY_OFS) ? {15'h0000, empty_reg} :
                  (adr_i == `ADDR_FULL_OFS) ? {15'h0000, full_reg} : 32'h00000000;

  // One-wait-state slave: ack one clock after the request, low the clock after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      cfg_reg <= `CFG_RESET;
    end else if (ce_i) begin
      ack_reg <= wb_take;
      dat_reg <= wb_take ? rd_mux : 32'h00000000;
      if (cfg_write) begin
        cfg_reg <= dat_i[3:0];
      end
    end
  end

  assign data_outputs_o = dout_reg;
  assign almost_empty_valid_o = empty_valid;
  assign almost_full_valid_o = full_valid;
  assign mem_write_o = mem_write_reg;
  assign mem_read_o = mem_read_reg;
  assign dat_o = dat_reg;
  assign ack_o = ack_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_serial_pause_hold: assert property ((ce_i && w_rise && !ld_n && sen_n) |=> $stable(ser_idx_reg))
    else $error("serial counter moved while serial enable was high");

  a_serial_wrap_home: assert property ((ce_i && ser_shift && ser_last) |=> ser_idx_reg == 6'h00)
    else $error("serial counter did not wrap after the last offset bit");

  a_serial_start_inval: assert property ((ce_i && ser_first && !ser_last)
                                         |=> !almost_empty_valid_o && !almost_full_valid_o)
    else $error("flags stayed valid after serial load began");

  a_full_settle_two: assert property ((ce_i && f_done) |=> !almost_full_valid_o)
    else $error("full flag valid in the edge after completion");

  a_par_start_inval: assert property ((ce_i && par_write && wp_reg == 3'h0) |=> !almost_full_valid_o)
    else $error("full flag stayed valid after parallel load began");

  a_mrst_home_ptrs: assert property ((ce_i && mrst) |=> wp_reg == 3'h0 && rp_reg == 3'h0)
    else $error("master reset did not home the offset pointers");

  a_wptr_in_range: assert property (wp_reg < 3'({w_parts, 1'b0}) || $changed(cfg_reg))
    else $error("write offset pointer outside the part range");

  a_read_overwrite: assert property ((ce_i && ofs_read) |=> data_outputs_o == $past(rd_word))
    else $error("offset read did not replace the data outputs");

  a_offset_no_memw: assert property ((ce_i && w_rise && !ld_n) |=> !mem_write_o)
    else $error("offset write advanced the memory write pointer");

  a_memw_redirect: assert property ((ce_i && w_rise && ld_n && !wen_n && !mrst) |=> mem_write_o)
    else $error("memory write missed while offset-load high");

  a_parallel_serial_excl: assert property ((ce_i && serial_mode_reg && w_rise) |=> $stable(wp_reg))
    else $error("parallel pointer moved in serial mode");
endmodule : flag_offset_programmer

/* File: dv/pin_host.sv */
`timescale 1ns/1ns
// Host on the pin side: slow pin clocks, controls held well around each edge
module pin_host (
  input wire logic clk_i,
  output logic write_clock_o,
  output logic read_clock_o,
  output logic master_reset_n_o,
  output logic serial_select_o,
  output logic [3:0] ctl_n_o,
  output logic serial_in_o,
  output fifo_ofs_pkg::word_t data_inputs_o
);
  import fifo_ofs_pkg::*;

  // Idle pins at time zero; ctl_n_o is {load, shift, write, read}
  initial begin
    write_clock_o = 1'b0;
    read_clock_o = 1'b0;
    master_reset_n_o = 1'b1;
    serial_select_o = 1'b0;
    ctl_n_o = 4'hF;
    serial_in_o = 1'b0;
    data_inputs_o = 18'h00000;
  end

  // One pin clock pulse; four system cycles per phase beats the synchroniser lag
  task automatic pulse(input logic wclk, input logic [3:0] ctl, input logic bit_v, input word_t d);
    ctl_n_o <= ctl;
    serial_in_o <= bit_v;
    data_inputs_o <= d;
    repeat (4) @(posedge clk_i);
    if (wclk) write_clock_o <= 1'b1;
    else read_clock_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    write_clock_o <= 1'b0;
    read_clock_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    ctl_n_o <= 4'hF;
    // A released line shows the inverse so stale data never looks valid
    serial_in_o <= ~bit_v;
    data_inputs_o <= ~d;
    @(posedge clk_i);
  endtask : pulse

  // Master reset latches the loading method
  task automatic mreset(input logic ser);
    master_reset_n_o <= 1'b0;
    serial_select_o <= ser;
    repeat (8) @(posedge clk_i);
    master_reset_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : mreset
endmodule : pin_host

/* File: dv/fifo_flag_offset_programmer_bench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module fifo_flag_offset_programmer_bench;
  import fifo_ofs_pkg::*;
  localparam logic [3:0] PW = 4'b0101, SH = 4'b0011, SP = 4'b0111, OR = 4'b0110;
  localparam logic [3:0] MW = 4'b1101, MR = 4'b1110, NOP = 4'b1111;
  logic clk_i = 1'b0, rst_i = 1'b1, fall_through_timing_i = 1'b0, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000, dat_o, q;
  word_t mem_read_data_i = 18'h00000, data_inputs, data_outputs_o;
  logic wclk, rclk, mr_n, ssel, si, ev, fv, mw_o, mr_o, ack_o;
  logic [3:0] ctl_n;
  int error_cnt = 0, checked = 0, cycles = 0, mw = 0, mr = 0;

  always #20 clk_i = ~clk_i;

  pin_host host (.clk_i(clk_i), .write_clock_o(wclk), .read_clock_o(rclk), .master_reset_n_o(mr_n),
    .serial_select_o(ssel), .ctl_n_o(ctl_n), .serial_in_o(si), .data_inputs_o(data_inputs));

  flag_offset_programmer DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .write_clock_i(wclk),
    .read_clock_i(rclk), .master_reset_n_i(mr_n), .offset_load_n_i(ctl_n[3]),
    .serial_shift_enable_n_i(ctl_n[2]), .write_enable_n_i(ctl_n[1]), .read_enable_n_i(ctl_n[0]),
    .serial_in_i(si), .serial_select_i(ssel), .data_inputs_i(data_inputs), .mem_read_data_i(mem_read_data_i),
    .fall_through_timing_i(fall_through_timing_i), .data_outputs_o(data_outputs_o),
    .almost_empty_valid_o(ev), .almost_full_valid_o(fv), .mem_write_o(mw_o), .mem_read_o(mr_o),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(4'hF), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .dat_o(dat_o), .ack_o(ack_o));

  // Memory strokes are counted to see that offset traffic never moves the pointers
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (mw_o === 1'b1) mw <= mw + 1;
    if (mr_o === 1'b1) mr <= mr + 1;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic t_reset();
    wb(0, 4'h8, 0); `CHK(q, 32'h0000007F)
    wb(0, 4'h1, 0); `CHK(q, 32'h00000000)
    `CHK({ev, fv}, 2'h3)
  endtask : t_reset

  task automatic t_par18();
    wb(1, 4'h0, 32'h00000003);
    host.pulse(1, PW, 0, 18'h1ABCD);
    `CHK({ev, fv}, 2'h0)
    host.pulse(1, MW, 0, 18'h3FFFF);
    wb(0, 4'hC, 0); `CHK(q, 32'h0000007F)
    host.pulse(1, PW, 0, 18'h00123);
    host.pulse(1, NOP, 0, 0);
    host.pulse(1, NOP, 0, 0);
    `CHK(fv, 1'b1)
    host.pulse(0, NOP, 0, 0);
    host.pulse(0, NOP, 0, 0);
    `CHK(ev, 1'b1)
    wb(0, 4'h8, 0); `CHK(q, 32'h0001ABCD)
    wb(0, 4'hC, 0); `CHK(q, 32'h00000123)
    `CHK(mw, 1)
  endtask : t_par18

  task automatic t_read18();
    fall_through_timing_i <= 1'b1;
    mem_read_data_i <= 18'h2AAAA;
    host.pulse(0, OR, 0, 0); `CHK(data_outputs_o, 18'h1ABCD)
    host.pulse(0, MR, 0, 0); `CHK(data_outputs_o, 18'h2AAAA)
    host.pulse(0, OR, 0, 0); `CHK(data_outputs_o, 18'h00123)
    host.pulse(0, OR, 0, 0); `CHK(data_outputs_o, 18'h1ABCD)
    host.pulse(0, OR, 0, 0); `CHK(data_outputs_o, 18'h00123)
    `CHK(mr, 1)
    fall_through_timing_i <= 1'b0;
  endtask : t_read18

  task automatic t_byte();
    logic [7:0] b [4] = '{8'h34, 8'h12, 8'h78, 8'h56};
    wb(1, 4'h0, 32'h00000000);
    foreach (b[i]) host.pulse(1, PW, 0, {10'h000, b[i]});
    wb(0, 4'h8, 0); `CHK(q[15:0], 16'h1234)
    wb(0, 4'hC, 0); `CHK(q[15:0], 16'h5678)
    foreach (b[i]) begin
      host.pulse(0, OR, 0, 0); `CHK(data_outputs_o, {10'h000, b[i]})
    end
    host.pulse(0, OR, 0, 0);
    host.mreset(1);
    wb(0, 4'h4, 0); `CHK({q[16], q[6:4], q[2:0]}, 7'h40)
  endtask : t_byte

  // Serial load with a pause and a memory write in the middle
  task automatic t_serial(input logic [3:0] cfg);
    int w;
    logic [16:0] m, e, f;
    w = 13 + cfg[3:2] + (cfg[1:0] == 2'h0);
    m = (17'h00001 << w) - 17'h00001;
    e = 17'h15555 & m;
    f = 17'h0AAAA & m;
    wb(1, 4'h0, {28'h0000000, cfg});
    for (int i = 0; i < 2 * w; i++) begin
      if (i == 5) begin
        host.pulse(1, SP, ~e[i], 0);
        host.pulse(1, MW, ~e[i], 0);
      end
      host.pulse(1, SH, (i < w) ? e[i] : f[i - w], 0);
      if (i == 0) `CHK({ev, fv}, 2'h0)
    end
    host.pulse(1, NOP, 0, 0);
    host.pulse(1, NOP, 0, 0);
    host.pulse(0, NOP, 0, 0);
    host.pulse(0, NOP, 0, 0);
    `CHK({ev, fv}, 2'h3)
    wb(0, 4'h8, 0); `CHK(q[16:0], e)
    wb(0, 4'hC, 0); `CHK(q[16:0], f)
  endtask : t_serial

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_par18();
    t_read18();
    t_byte();
    t_serial(4'h3);
    host.pulse(0, OR, 0, 0); `CHK(data_outputs_o, 18'h15555 & 18'h01FFF)
    t_serial(4'hC);
    `CHK(mw, 3)
    give_verdict();
  end
endmodule : fifo_flag_offset_programmer_bench
